// >>> rtl/dlr_pkg.sv
// Package for the diagnostic and delay-line register bank.
// Assumes 16-bit processor I/O accesses decoded on a full 16-bit port address.
package dlr_pkg;
  localparam logic [15:0] PROBE_SELECT_PORT = 16'h9872;
  localparam logic [15:0] DELAY_PORT = 16'hA072;
  localparam logic [15:0] ALT_GATE_PORT = 16'h0092;
  localparam logic [15:0] PM_OUT_PORT = 16'h7072;
  localparam int REV_HI = 15;
  localparam int REV_LO = 13;
  localparam int CLK_TEST_BIT = 12;
  localparam int MASTER_REF_BIT = 11;
  localparam int AUTO_GATE_BIT = 10;
  localparam int UNUSED_BIT = 9;
  localparam int SWITCH_WIDTH_BIT = 8;
  localparam int PROC_TYPE_BIT = 7;
  localparam int READBACK_BIT = 6;
  localparam int SEL_HI = 5;
  localparam int LOCK_BIT = 7;
  localparam int FREEZE_BIT = 6;
  localparam int COUNT_HI = 5;
  localparam int ALT_GATE_BIT = 1;
  localparam int PM_GATE_BIT = 6;
  localparam logic [5:0] SEL_SPEAKER_NORMAL = 6'h00;
  localparam logic [5:0] SEL_SPEAKER_OFF = 6'h01;
  localparam logic [5:0] COUNT_RESET = 6'h20;
  localparam logic [5:0] COUNT_MAX = 6'h3F;
  localparam logic [2:0] REVISION = 3'h5;  // Arbitrary value
  // Clock-switch reset pulse timing at 25 MHz
  localparam int CLK_PERIOD_PS = 40000;
  localparam int SHORT_US = 1;
  localparam int SHORT_EXTRA_CLKS = 16;
  localparam int LONG_MS = 1;
  localparam int SHORT_CYCLES = (SHORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
    + SHORT_EXTRA_CLKS;
  localparam int LONG_CYCLES = (LONG_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_W = 15;
endpackage

// >>> rtl/dlr_pulse.sv
// Clock-switch reset pulse generator.
// Assumes the start request is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module dlr_pulse #(
  parameter int LONG_CYCLES = dlr_pkg::LONG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_long,
  output logic o_pulse
);
  logic [dlr_pkg::PULSE_W-1:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else if (i_start) begin
      cnt_q <= i_long ? dlr_pkg::PULSE_W'(LONG_CYCLES) :
        dlr_pkg::PULSE_W'(dlr_pkg::SHORT_CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_pulse = (cnt_q != '0);
endmodule // dlr_pulse

// >>> rtl/dlr_regs.sv
// Diagnostic and delay-line register bank of the system controller.
// Assumes synchronous, same-clock I/O strobes; pins i_proc_type and i_probe_sig are async.
`timescale 1ns/1ps
module dlr_regs #(
  parameter int LONG_CYCLES = dlr_pkg::LONG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_io_addr,
  input wire logic [15:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  output logic [15:0] o_io_rdata,
  input wire logic i_proc_type,
  input wire logic i_kbd_gate,
  input wire logic i_kbd_data_d1_rd,
  input wire logic i_refresh,
  input wire logic i_master_refresh_req,
  input wire logic i_calib_up,
  input wire logic i_clock_switch,
  input wire logic [63:0] i_probe_sig,
  input wire logic i_speaker_in,
  output logic o_speaker,
  output logic o_probe_select_out,
  output logic o_gate_a20,
  output logic o_kbd_gate_rd,
  output logic o_master_refresh_ack,
  output logic [5:0] o_drive_strength,
  output logic o_calib_cycle,
  output logic o_switch_reset
);
  logic factory_clock_test_q;
  logic master_refresh_support_q;
  logic auto_gate_tracking_q;
  logic switch_reset_width_q;
  logic processor_type_flag_q;
  logic [5:0] probe_select_q;
  logic probe_readback_q;
  logic strength_lock_q;
  logic calibration_freeze_q;
  logic [5:0] delay_count_q;
  logic [5:0] strength_q;
  logic alternate_gate_control_q;
  logic pm_gate_q;
  logic [15:0] rdata_q;
  logic [1:0] type_sync_q;
  logic type_sampled_q;
  logic [1:0] type_fill_q;
  logic [63:0] probe_s1_q;
  logic [63:0] probe_s2_q;
  logic wr_probe_select;
  logic wr_delay;
  logic wr_alt;
  logic gate_eff;

  assign wr_probe_select = i_io_wr && (i_io_addr == dlr_pkg::PROBE_SELECT_PORT);
  assign wr_delay = i_io_wr && (i_io_addr == dlr_pkg::DELAY_PORT);
  assign wr_alt = i_io_wr && (i_io_addr == dlr_pkg::ALT_GATE_PORT);

  // Synchronisers for pins from outside the clock domain
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      type_sync_q <= 2'h0;
      probe_s1_q <= '0;
      probe_s2_q <= '0;
    end else begin
      type_sync_q <= {type_sync_q[0], i_proc_type};
      probe_s1_q <= i_probe_sig;
      probe_s2_q <= probe_s1_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      processor_type_flag_q <= 1'b0;
      type_sampled_q <= 1'b0;
      type_fill_q <= 2'h0;
    end else if (!type_sampled_q) begin
      // Wait two edges so the synchroniser holds the strap, not its reset value
      if (type_fill_q == 2'h2) begin
        processor_type_flag_q <= type_sync_q[1];
        type_sampled_q <= 1'b1;
      end else begin
        type_fill_q <= type_fill_q + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      factory_clock_test_q <= 1'b0;
      master_refresh_support_q <= 1'b0;
      auto_gate_tracking_q <= 1'b0;
      switch_reset_width_q <= 1'b0;
      probe_select_q <= dlr_pkg::SEL_SPEAKER_NORMAL;
    end else if (wr_probe_select) begin
      factory_clock_test_q <= 1'b0;
      master_refresh_support_q <= i_io_wdata[dlr_pkg::MASTER_REF_BIT];
      auto_gate_tracking_q <= i_io_wdata[dlr_pkg::AUTO_GATE_BIT];
      switch_reset_width_q <= i_io_wdata[dlr_pkg::SWITCH_WIDTH_BIT];
      probe_select_q <= i_io_wdata[dlr_pkg::SEL_HI:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      probe_readback_q <= 1'b0;
    end else begin
      probe_readback_q <= probe_s2_q[probe_select_q];
    end
  end

  assign o_speaker = (probe_select_q == dlr_pkg::SEL_SPEAKER_OFF) ? 1'b0 : i_speaker_in;
  assign o_probe_select_out = 1'b0;

  assign o_master_refresh_ack = master_refresh_support_q && i_master_refresh_req;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      alternate_gate_control_q <= 1'b0;
    end else if (wr_alt) begin
      alternate_gate_control_q <= i_io_wdata[dlr_pkg::ALT_GATE_BIT];
    end else if (auto_gate_tracking_q) begin
      alternate_gate_control_q <= i_kbd_gate;
    end
  end

  assign gate_eff = alternate_gate_control_q | i_kbd_gate;
  assign o_gate_a20 = gate_eff;

  assign o_kbd_gate_rd = i_kbd_data_d1_rd ? alternate_gate_control_q : i_kbd_gate;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pm_gate_q <= 1'b0;
    end else if (wr_alt) begin
      pm_gate_q <= i_io_wdata[dlr_pkg::ALT_GATE_BIT] | i_kbd_gate;
    end else if (i_refresh) begin
      pm_gate_q <= gate_eff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      strength_lock_q <= 1'b0;
      calibration_freeze_q <= 1'b0;
    end else if (wr_delay) begin
      strength_lock_q <= i_io_wdata[dlr_pkg::LOCK_BIT];
      calibration_freeze_q <= i_io_wdata[dlr_pkg::FREEZE_BIT];
    end
  end

  assign o_calib_cycle = i_refresh && !calibration_freeze_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      delay_count_q <= dlr_pkg::COUNT_RESET;
    end else if (wr_delay && calibration_freeze_q) begin
      delay_count_q <= i_io_wdata[dlr_pkg::COUNT_HI:0];
    end else if (o_calib_cycle) begin
      if (i_calib_up && delay_count_q != dlr_pkg::COUNT_MAX) begin
        delay_count_q <= delay_count_q + 6'h01;
      end else if (!i_calib_up && delay_count_q != 6'h00) begin
        delay_count_q <= delay_count_q - 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      strength_q <= dlr_pkg::COUNT_RESET;
    end else if (!strength_lock_q) begin
      strength_q <= delay_count_q;
    end
  end
  assign o_drive_strength = strength_q;

  dlr_pulse #(
    .LONG_CYCLES(LONG_CYCLES)
  ) u_pulse (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(i_clock_switch),
    .i_long(switch_reset_width_q),
    .o_pulse(o_switch_reset)
  );

  // Read mux; revision and read-only bits come from hardware only
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= 16'h0000;
    end else if (i_io_rd) begin
      if (i_io_addr == dlr_pkg::PROBE_SELECT_PORT) begin
        rdata_q <= {dlr_pkg::REVISION, factory_clock_test_q, master_refresh_support_q,
          auto_gate_tracking_q, 1'b0, switch_reset_width_q, processor_type_flag_q,
          probe_readback_q, probe_select_q};
      end else if (i_io_addr == dlr_pkg::DELAY_PORT) begin
        rdata_q <= {8'h00, strength_lock_q, calibration_freeze_q, delay_count_q};
      end else if (i_io_addr == dlr_pkg::ALT_GATE_PORT) begin
        rdata_q <= {14'h0000, alternate_gate_control_q, 1'b0};
      end else if (i_io_addr == dlr_pkg::PM_OUT_PORT) begin
        rdata_q <= {9'h000, pm_gate_q, 6'h00};
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end
  assign o_io_rdata = rdata_q;
endmodule // dlr_regs

// >>> verif/dlr_regs_props.sv
// Checker for the diagnostic and delay-line register bank.
// Sees only top-level ports; bound onto every dlr_regs instance.
`timescale 1ns/1ps
module dlr_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic [15:0] o_io_rdata,
  input wire logic i_kbd_gate,
  input wire logic o_gate_a20,
  input wire logic i_master_refresh_req,
  input wire logic o_master_refresh_ack,
  input wire logic i_refresh,
  input wire logic o_calib_cycle,
  input wire logic i_clock_switch,
  input wire logic o_switch_reset,
  input wire logic o_probe_select_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic drd;
  assign drd = i_io_rd && (i_io_addr == dlr_pkg::PROBE_SELECT_PORT);
  property p_zero_bits; drd |=> !o_io_rdata[12] && !o_io_rdata[9]; endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("bit 12 or 9 read as one");
  property p_rev; drd |=> o_io_rdata[15:13] == dlr_pkg::REVISION; endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");
  property p_no_probe_select; i_resetn |-> !o_probe_select_out; endproperty
  a_no_probe_select: assert property (p_no_probe_select) else $error("diagnostic output active");
  property p_ack; o_master_refresh_ack |-> i_master_refresh_req; endproperty
  a_ack: assert property (p_ack) else $error("refresh ack without request");
  property p_calib; o_calib_cycle |-> i_refresh; endproperty
  a_calib: assert property (p_calib) else $error("calibration outside refresh");
  property p_gate_or; i_kbd_gate |-> o_gate_a20; endproperty
  a_gate_or: assert property (p_gate_or) else $error("gate low with keyboard gate high");
  property p_sw_cause; $rose(o_switch_reset) |-> $past(i_clock_switch); endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("switch reset without switch");
  property p_sw_min; $rose(o_switch_reset) |-> o_switch_reset [*8]; endproperty
  a_sw_min: assert property (p_sw_min) else $error("switch reset pulse too short");
  c_ack: cover property (o_master_refresh_ack);
  c_calib: cover property (o_calib_cycle);
  c_sw: cover property ($rose(o_switch_reset));
endmodule // dlr_props
bind dlr_regs dlr_props u_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_io_addr(i_io_addr),
  .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata), .i_kbd_gate(i_kbd_gate), .o_gate_a20(o_gate_a20),
  .i_master_refresh_req(i_master_refresh_req), .o_master_refresh_ack(o_master_refresh_ack),
  .i_refresh(i_refresh), .o_calib_cycle(o_calib_cycle), .i_clock_switch(i_clock_switch),
  .o_switch_reset(o_switch_reset), .o_probe_select_out(o_probe_select_out));

// >>> verif/tb.sv
// Self-checking bench for the diagnostic and delay-line register bank.
// Drives pins at the falling edge; register reads are scored from a queue.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic kbd = 1'b0, d1 = 1'b0, refr = 1'b0, mreq = 1'b0, up = 1'b1, csw = 1'b0, spk = 1'b1;
  logic [63:0] probe = 64'h0;
  logic spk_o, probe_select_o, gate, kgr, ack, calib, swr;
  logic [5:0] drv;
  logic [15:0] expq[$];
  int num_errors = 0, checks = 0;
  localparam logic [15:0] DG = dlr_pkg::PROBE_SELECT_PORT;
  localparam logic [15:0] DLY = dlr_pkg::DELAY_PORT;
  always #20 clk = ~clk;
  dlr_regs #(.LONG_CYCLES(50)) dut_u (.i_clk(clk), .i_resetn(resetn), .i_io_addr(addr),
    .i_io_wdata(wdata), .i_io_wr(wr), .i_io_rd(rd), .o_io_rdata(rdata), .i_proc_type(1'b1),
    .i_kbd_gate(kbd), .i_kbd_data_d1_rd(d1), .i_refresh(refr), .i_master_refresh_req(mreq),
    .i_calib_up(up), .i_clock_switch(csw), .i_probe_sig(probe), .i_speaker_in(spk),
    .o_speaker(spk_o), .o_probe_select_out(probe_select_o), .o_gate_a20(gate), .o_kbd_gate_rd(kgr),
    .o_master_refresh_ack(ack), .o_drive_strength(drv), .o_calib_cycle(calib),
    .o_switch_reset(swr));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    expq.push_back(e);
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic tick(input logic e);
    @(negedge clk);
    refr = 1'b1;
    // Sample the combinational pulse away from the edge that updates freeze
    @(negedge clk);
    cmp(16'(calib), 16'(e));
    refr = 1'b0;
  endtask
  task automatic sw_len(input int e);
    int n;
    n = 0;
    @(negedge clk);
    csw = 1'b1;
    @(negedge clk);
    csw = 1'b0;
    for (int k = 0; k < 4 && swr !== 1'b1; k++) @(negedge clk);
    while (swr === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
    cmp(16'(n), 16'(e));
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) cmp(rdata, expq.pop_front());
  end
  initial begin
    void'($urandom(32'hA706));
    probe = {$urandom, $urandom};
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    rd_reg(DG, {dlr_pkg::REVISION, 6'b000001, probe[0], 6'h00});
    rd_reg(DLY, 16'h0020);
    rd_reg(16'h1234, 16'h0000);
    $display("done: reset values");
    wr_reg(DG, 16'hFFFF);
    repeat (2) @(negedge clk);
    rd_reg(DG, {dlr_pkg::REVISION, 6'b011011, probe[63], 6'h3F});
    mreq = 1'b1;
    @(negedge clk);
    cmp(16'(ack), 16'h0001);
    mreq = 1'b0;
    wr_reg(DG, 16'h0401);
    kbd = 1'b1;
    repeat (3) @(negedge clk);
    cmp(16'(spk_o), 16'h0000);
    wr_reg(DG, 16'h0000);
    kbd = 1'b0;
    @(negedge clk);
    cmp(16'(gate), 16'h0001);
    d1 = 1'b1;
    mreq = 1'b1;
    @(negedge clk);
    cmp({14'h0, kgr, ack}, 16'h0002);
    {d1, mreq} = 2'b00;
    wr_reg(dlr_pkg::ALT_GATE_PORT, 16'h0000);
    @(negedge clk);
    cmp({14'h0, gate, spk_o}, 16'h0001);
    wr_reg(dlr_pkg::ALT_GATE_PORT, 16'h0002);
    rd_reg(dlr_pkg::PM_OUT_PORT, 16'h0040);
    rd_reg(dlr_pkg::ALT_GATE_PORT, 16'h0002);
    wr_reg(dlr_pkg::ALT_GATE_PORT, 16'h0000);
    kbd = 1'b1;
    // Keyboard path alone must not move the mirror before a refresh
    rd_reg(dlr_pkg::PM_OUT_PORT, 16'h0000);
    $display("done: diagnostic register");
    wr_reg(DLY, 16'h0015);
    rd_reg(DLY, 16'h0020);
    wr_reg(DLY, 16'h0040);
    wr_reg(DLY, 16'h0055);
    rd_reg(DLY, 16'h0055);
    repeat (2) @(negedge clk);
    cmp(16'(drv), 16'h0015);
    wr_reg(DLY, 16'h00CA);
    repeat (3) @(negedge clk);
    cmp(16'(drv), 16'h0015);
    wr_reg(DLY, 16'h000A);
    repeat (3) tick(1'b1);
    repeat (3) @(negedge clk);
    cmp(16'(drv), 16'h000D);
    wr_reg(DLY, 16'h004D);
    tick(1'b0);
    rd_reg(DLY, 16'h004D);
    rd_reg(dlr_pkg::PM_OUT_PORT, 16'h0040);
    $display("done: delay line");
    sw_len(dlr_pkg::SHORT_CYCLES);
    wr_reg(DG, 16'h0100);
    sw_len(50);
    $display("done: switch reset");
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule // tb
